/* File: design/peripheral_select_pin_mux.sv */
`timescale 1ns/1ns
`default_nettype none

module peripheral_select_pin_mux
	import pin_mux_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Reset straps
	input wire logic pci_select_strap,
	input wire logic ethernet_select_strap,
	input wire logic host_width_strap,
	// Configuration bus
	input wire logic config_bus_req,
	input wire logic config_bus_write,
	input wire logic [31:0] config_bus_addr,
	input wire logic [31:0] config_bus_wdata,
	output logic config_bus_ack,
	output logic [31:0] config_bus_rdata,
	// Peripheral selection from straps
	output logic host_port_enable,
	output logic host_port_32bit,
	output logic ethernet_mac_enable,
	output logic pci_enable,
	// Peripheral enables from the configuration register, lock state from the lock register
	output logic video2_enable,
	output logic video1_enable,
	output logic video0_enable,
	output logic two_wire_ctrl_enable,
	output logic serial1_enable,
	output logic serial0_enable,
	output logic audio_port_enable,
	output logic lock_state_flag,
	// Video 0 lower pins shared with serial port 0
	input wire logic [LOWER_GROUP_WIDTH-1:0] video0_lower_out,
	input wire logic [LOWER_GROUP_WIDTH-1:0] video0_lower_oe,
	output logic [LOWER_GROUP_WIDTH-1:0] video0_lower_in,
	input wire logic [LOWER_GROUP_WIDTH-1:0] serial0_out,
	input wire logic [LOWER_GROUP_WIDTH-1:0] serial0_oe,
	output logic [LOWER_GROUP_WIDTH-1:0] serial0_in,
	input wire logic [LOWER_GROUP_WIDTH-1:0] pad0_lower_in,
	output logic [LOWER_GROUP_WIDTH-1:0] pad0_lower_out,
	output logic [LOWER_GROUP_WIDTH-1:0] pad0_lower_oe,
	// Video 1 lower pins shared with serial port 1
	input wire logic [LOWER_GROUP_WIDTH-1:0] video1_lower_out,
	input wire logic [LOWER_GROUP_WIDTH-1:0] video1_lower_oe,
	output logic [LOWER_GROUP_WIDTH-1:0] video1_lower_in,
	input wire logic [LOWER_GROUP_WIDTH-1:0] serial1_out,
	input wire logic [LOWER_GROUP_WIDTH-1:0] serial1_oe,
	output logic [LOWER_GROUP_WIDTH-1:0] serial1_in,
	input wire logic [LOWER_GROUP_WIDTH-1:0] pad1_lower_in,
	output logic [LOWER_GROUP_WIDTH-1:0] pad1_lower_out,
	output logic [LOWER_GROUP_WIDTH-1:0] pad1_lower_oe,
	// Video 0 upper pins shared with audio clocks, frames and mutes
	input wire logic [UPPER_GROUP_WIDTH-1:0] video0_upper_out,
	input wire logic [UPPER_GROUP_WIDTH-1:0] video0_upper_oe,
	output logic [UPPER_GROUP_WIDTH-1:0] video0_upper_in,
	input wire logic [UPPER_GROUP_WIDTH-1:0] audio_ctrl_out,
	input wire logic [UPPER_GROUP_WIDTH-1:0] audio_ctrl_oe,
	output logic [UPPER_GROUP_WIDTH-1:0] audio_ctrl_in,
	input wire logic [UPPER_GROUP_WIDTH-1:0] pad0_upper_in,
	output logic [UPPER_GROUP_WIDTH-1:0] pad0_upper_out,
	output logic [UPPER_GROUP_WIDTH-1:0] pad0_upper_oe,
	// Video 1 upper pins shared with audio data lines
	input wire logic [UPPER_GROUP_WIDTH-1:0] video1_upper_out,
	input wire logic [UPPER_GROUP_WIDTH-1:0] video1_upper_oe,
	output logic [UPPER_GROUP_WIDTH-1:0] video1_upper_in,
	input wire logic [UPPER_GROUP_WIDTH-1:0] audio_data_out,
	input wire logic [UPPER_GROUP_WIDTH-1:0] audio_data_oe,
	output logic [UPPER_GROUP_WIDTH-1:0] audio_data_in,
	input wire logic [UPPER_GROUP_WIDTH-1:0] pad1_upper_in,
	output logic [UPPER_GROUP_WIDTH-1:0] pad1_upper_out,
	output logic [UPPER_GROUP_WIDTH-1:0] pad1_upper_oe
);

	////////////////////////////////////////////////////////////////////////////
	// State
	strap_t strap;
	periph_cfg_t peripheral_config;
	logic locked;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	cfg_req_t bus;
	assign bus = '{req: config_bus_req, write: config_bus_write,
		addr: config_bus_addr, wdata: config_bus_wdata};

	wire logic in_region = (bus.addr & CFG_REGION_MASK) == CFG_REGION_BASE;
	wire logic hit = bus.req && in_region;
	wire logic hit_pcfg = hit && bus.addr == PERIPHERAL_CONFIG_ADDR;
	wire logic hit_lock = hit && bus.addr == CONFIG_LOCK_ADDR;
	wire logic pcfg_write = hit_pcfg && bus.write;
	wire logic lock_write = hit_lock && bus.write;
	wire logic key_match = bus.wdata == UNLOCK_KEY;

	wire periph_cfg_t next_peripheral_config =
		(pcfg_write && !locked) ? periph_cfg_t'(bus.wdata[PCFG_WIDTH-1:0])
		: peripheral_config;
	wire logic next_locked = pcfg_write ? 1'b1
		: (lock_write ? !key_match : locked);

	wire logic [31:0] pcfg_word = {PCFG_RESERVED_VALUE, peripheral_config};
	wire logic [31:0] lock_word = {LOCK_RESERVED_VALUE, locked};
	wire logic [31:0] next_rdata = (hit && !bus.write)
		? (hit_pcfg ? pcfg_word : (hit_lock ? lock_word : 32'h00000000))
		: 32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// Strap capture while reset is held
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			strap <= '{sel: periph_sel_t'({pci_select_strap, ethernet_select_strap}),
				host_width: host_width_strap};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration and lock registers
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			peripheral_config <= periph_cfg_t'(PCFG_RESET);
			locked <= LOCK_RESET;
		end
		else
		begin
			peripheral_config <= next_peripheral_config;
			locked <= next_locked;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus answer
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			config_bus_ack <= 1'b0;
			config_bus_rdata <= 32'h00000000;
		end
		else
		begin
			config_bus_ack <= hit;
			config_bus_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Peripheral selection decode from held straps
	logic next_host_enable;
	logic next_host_32;
	logic next_ethernet;
	logic next_pci;

	always_comb
	begin
		next_host_enable = 1'b0;
		next_host_32 = 1'b0;
		next_ethernet = 1'b0;
		next_pci = 1'b0;
		unique case (strap.sel)
			SEL_HOST:
			begin
				next_host_enable = 1'b1;
				next_host_32 = strap.host_width;
			end
			SEL_ETHERNET:
			begin
				next_ethernet = 1'b1;
				next_host_enable = !strap.host_width;
			end
			SEL_PCI:
			begin
				next_pci = 1'b1;
			end
			SEL_RESERVED:
			begin
				next_pci = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			host_port_enable <= 1'b0;
			host_port_32bit <= 1'b0;
			ethernet_mac_enable <= 1'b0;
			pci_enable <= 1'b0;
		end
		else
		begin
			host_port_enable <= next_host_enable;
			host_port_32bit <= next_host_32;
			ethernet_mac_enable <= next_ethernet;
			pci_enable <= next_pci;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Enables straight from the configuration register, lock flag straight from the lock register
	assign video2_enable = peripheral_config.video2_enable;
	assign video1_enable = peripheral_config.video1_enable;
	assign video0_enable = peripheral_config.video0_enable;
	assign two_wire_ctrl_enable = peripheral_config.two_wire_ctrl_enable;
	assign serial1_enable = peripheral_config.serial1_select;
	assign serial0_enable = peripheral_config.serial0_select;
	assign audio_port_enable = peripheral_config.audio_port_select;
	assign lock_state_flag = locked;

	////////////////////////////////////////////////////////////////////////////
	// Shared pin groups
	shared_pin_group #(.WIDTH(LOWER_GROUP_WIDTH)) lower0_group
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.alt_owns(peripheral_config.serial0_select),
		.primary_allowed(peripheral_config.video0_enable),
		.pri_out(video0_lower_out),
		.pri_oe(video0_lower_oe),
		.pri_in(video0_lower_in),
		.alt_out(serial0_out),
		.alt_oe(serial0_oe),
		.alt_in(serial0_in),
		.pad_in(pad0_lower_in),
		.pad_out(pad0_lower_out),
		.pad_oe(pad0_lower_oe)
	);

	shared_pin_group #(.WIDTH(LOWER_GROUP_WIDTH)) lower1_group
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.alt_owns(peripheral_config.serial1_select),
		.primary_allowed(peripheral_config.video1_enable),
		.pri_out(video1_lower_out),
		.pri_oe(video1_lower_oe),
		.pri_in(video1_lower_in),
		.alt_out(serial1_out),
		.alt_oe(serial1_oe),
		.alt_in(serial1_in),
		.pad_in(pad1_lower_in),
		.pad_out(pad1_lower_out),
		.pad_oe(pad1_lower_oe)
	);

	shared_pin_group #(.WIDTH(UPPER_GROUP_WIDTH)) upper0_group
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.alt_owns(peripheral_config.audio_port_select),
		.primary_allowed(peripheral_config.video0_enable),
		.pri_out(video0_upper_out),
		.pri_oe(video0_upper_oe),
		.pri_in(video0_upper_in),
		.alt_out(audio_ctrl_out),
		.alt_oe(audio_ctrl_oe),
		.alt_in(audio_ctrl_in),
		.pad_in(pad0_upper_in),
		.pad_out(pad0_upper_out),
		.pad_oe(pad0_upper_oe)
	);

	shared_pin_group #(.WIDTH(UPPER_GROUP_WIDTH)) upper1_group
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.alt_owns(peripheral_config.audio_port_select),
		.primary_allowed(peripheral_config.video1_enable),
		.pri_out(video1_upper_out),
		.pri_oe(video1_upper_oe),
		.pri_in(video1_upper_in),
		.alt_out(audio_data_out),
		.alt_oe(audio_data_oe),
		.alt_in(audio_data_in),
		.pad_in(pad1_upper_in),
		.pad_out(pad1_upper_out),
		.pad_oe(pad1_upper_oe)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_write_relocks: assert property (@(posedge mclk) disable iff (!reset_n)
		pcfg_write |=> locked ##1 (locked || $past(lock_write)))
		else $error("configuration write left the lock open");

	chk_locked_ignores: assert property (@(posedge mclk) disable iff (!reset_n)
		(pcfg_write && locked) |=> $stable(peripheral_config))
		else $error("locked configuration register changed");

	chk_key_unlocks: assert property (@(posedge mclk) disable iff (!reset_n)
		(lock_write && key_match) |=> (!locked && config_bus_ack))
		else $error("unlock key did not open the lock");

	chk_unlocked_takes: assert property (@(posedge mclk) disable iff (!reset_n)
		(pcfg_write && !locked) |=> peripheral_config == $past(bus.wdata[PCFG_WIDTH-1:0]))
		else $error("unlocked write not stored");

	chk_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
		(hit_pcfg && !bus.write) |=> (config_bus_ack && config_bus_rdata[31:PCFG_WIDTH] == '0))
		else $error("reserved configuration bits read nonzero");

	chk_region_ack: assert property (@(posedge mclk) disable iff (!reset_n)
		config_bus_req |=> (config_bus_ack == $past(in_region)))
		else $error("region decode answered wrongly");

	chk_reset_value: assert property (@(posedge mclk)
		!reset_n |=> (peripheral_config == PCFG_RESET && !audio_port_enable && locked))
		else $error("configuration reset value wrong");

	chk_strap_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		$past(reset_n) |-> $stable(strap))
		else $error("straps changed after reset");

	chk_host_width: assert property (@(posedge mclk) disable iff (!reset_n)
		host_port_32bit |-> (strap.sel == SEL_HOST && strap.host_width && host_port_enable))
		else $error("host port 32-bit without matching straps");

	chk_ethernet_host: assert property (@(posedge mclk) disable iff (!reset_n)
		(ethernet_mac_enable && strap.host_width) |-> !host_port_enable)
		else $error("host port left on with ethernet and wide strap");

endmodule

`default_nettype wire

/* File: design/shared_pin_group.sv */
`timescale 1ns/1ns
`default_nettype none

module shared_pin_group
	import pin_mux_pkg::*;
#(
	parameter int WIDTH = LOWER_GROUP_WIDTH
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Ownership
	input wire logic alt_owns,
	input wire logic primary_allowed,
	// Primary function
	input wire logic [WIDTH-1:0] pri_out,
	input wire logic [WIDTH-1:0] pri_oe,
	output logic [WIDTH-1:0] pri_in,
	// Alternate function
	input wire logic [WIDTH-1:0] alt_out,
	input wire logic [WIDTH-1:0] alt_oe,
	output logic [WIDTH-1:0] alt_in,
	// Pads
	input wire logic [WIDTH-1:0] pad_in,
	output logic [WIDTH-1:0] pad_out,
	output logic [WIDTH-1:0] pad_oe
);

	if (WIDTH < 1)
	begin : g_bad_width
		$error("shared_pin_group: WIDTH must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////////
	// Owner selection; a function not owning the group sees zeros
	wire logic pri_owns = !alt_owns && primary_allowed;
	wire logic [WIDTH-1:0] next_pad_out = alt_owns ? alt_out : (pri_owns ? pri_out : '0);
	wire logic [WIDTH-1:0] next_pad_oe = alt_owns ? alt_oe : (pri_owns ? pri_oe : '0);
	wire logic [WIDTH-1:0] next_pri_in = pri_owns ? pad_in : '0;
	wire logic [WIDTH-1:0] next_alt_in = alt_owns ? pad_in : '0;

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			pad_out <= '0;
			pad_oe <= '0;
			pri_in <= '0;
			alt_in <= '0;
		end
		else
		begin
			pad_out <= next_pad_out;
			pad_oe <= next_pad_oe;
			pri_in <= next_pri_in;
			alt_in <= next_alt_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_idle_group_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
		(!alt_owns && !primary_allowed) |=> (pad_oe == '0 && pri_in == '0 && alt_in == '0))
		else $error("unowned pin group still active");

	chk_alt_owner_drives: assert property (@(posedge mclk) disable iff (!reset_n)
		(reset_n && alt_owns) |=>
		(pri_in == '0 && alt_in == $past(pad_in) && pad_oe == $past(alt_oe)))
		else $error("alternate owner not routed to pads");

endmodule

`default_nettype wire

/* File: shared/pin_mux_pkg.sv */
package pin_mux_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Configuration region and register map
	localparam logic [31:0] CFG_REGION_BASE = 32'h01b3f000;
	localparam int CFG_REGION_BYTES = 4096;
	localparam logic [31:0] CFG_REGION_MASK = 32'hfffff000;
	localparam logic [31:0] PERIPHERAL_CONFIG_ADDR = 32'h01b3f000;
	localparam logic [31:0] CONFIG_LOCK_ADDR = 32'h01b3f018;
	localparam logic [31:0] UNLOCK_KEY = 32'h10c0010c;

	////////////////////////////////////////////////////////////////////////////
	// Peripheral configuration fields
	localparam int PCFG_WIDTH = 7;
	localparam int BIT_VIDEO2 = 6;
	localparam int BIT_VIDEO1 = 5;
	localparam int BIT_VIDEO0 = 4;
	localparam int BIT_TWO_WIRE = 3;
	localparam int BIT_SERIAL1 = 2;
	localparam int BIT_SERIAL0 = 1;
	localparam int BIT_AUDIO = 0;
	localparam logic [6:0] PCFG_RESET = 7'h06;
	localparam logic [24:0] PCFG_RESERVED_VALUE = 25'h0000000;
	localparam logic [30:0] LOCK_RESERVED_VALUE = 31'h00000000;
	localparam logic LOCK_RESET = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// Shared pin groups
	localparam int LOWER_GROUP_MSB = 8;
	localparam int LOWER_GROUP_LSB = 2;
	localparam int LOWER_GROUP_WIDTH = LOWER_GROUP_MSB - LOWER_GROUP_LSB + 1;
	localparam int UPPER_GROUP_MSB = 19;
	localparam int UPPER_GROUP_LSB = 12;
	localparam int UPPER_GROUP_WIDTH = UPPER_GROUP_MSB - UPPER_GROUP_LSB + 1;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0]
	{
		SEL_HOST = 2'b00,
		SEL_ETHERNET = 2'b01,
		SEL_PCI = 2'b10,
		SEL_RESERVED = 2'b11
	} periph_sel_t;

	typedef struct packed
	{
		logic video2_enable;
		logic video1_enable;
		logic video0_enable;
		logic two_wire_ctrl_enable;
		logic serial1_select;
		logic serial0_select;
		logic audio_port_select;
	} periph_cfg_t;

	typedef struct packed
	{
		periph_sel_t sel;
		logic host_width;
	} strap_t;

	typedef struct packed
	{
		logic req;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} cfg_req_t;

endpackage

/* File: test/test_peripheral_select_pin_mux.sv */
`timescale 1ns/1ns
`default_nettype none

module test_peripheral_select_pin_mux
	import pin_mux_pkg::*;
;
	////////////////////////////////////////////////////////////////////////////
	// Stimulus and observed signals
	logic mclk, reset_n, pci_select_strap, ethernet_select_strap, host_width_strap;
	logic config_bus_req, config_bus_write, config_bus_ack;
	logic [31:0] config_bus_addr, config_bus_wdata, config_bus_rdata;
	logic host_port_enable, host_port_32bit, ethernet_mac_enable, pci_enable;
	logic video2_enable, video1_enable, video0_enable, two_wire_ctrl_enable;
	logic serial1_enable, serial0_enable, audio_port_enable, lock_state_flag;
	logic [6:0] video0_lower_out, video0_lower_oe, video0_lower_in, serial0_out, serial0_oe;
	logic [6:0] serial0_in, pad0_lower_in, pad0_lower_out, pad0_lower_oe;
	logic [6:0] video1_lower_out, video1_lower_oe, video1_lower_in, serial1_out, serial1_oe;
	logic [6:0] serial1_in, pad1_lower_in, pad1_lower_out, pad1_lower_oe;
	logic [7:0] video0_upper_out, video0_upper_oe, video0_upper_in, audio_ctrl_out, audio_ctrl_oe;
	logic [7:0] audio_ctrl_in, pad0_upper_in, pad0_upper_out, pad0_upper_oe;
	logic [7:0] video1_upper_out, video1_upper_oe, video1_upper_in, audio_data_out, audio_data_oe;
	logic [7:0] audio_data_in, pad1_upper_in, pad1_upper_out, pad1_upper_oe;
	logic [7:0] pat, q;
	int bad_count, n_compared;

	// Function inputs follow one pattern, shuffled so every source within a group differs
	assign q = {pat[3:0], pat[7:4]};
	assign video0_lower_out = pat[6:0];
	assign video0_lower_oe = pat[7:1];
	assign serial0_out = ~pat[6:0];
	assign serial0_oe = ~pat[7:1];
	assign pad0_lower_in = q[6:0];
	assign video1_lower_out = q[6:0];
	assign video1_lower_oe = pat[6:0];
	assign serial1_out = ~q[6:0];
	assign serial1_oe = ~pat[6:0];
	assign pad1_lower_in = pat[7:1];
	assign video0_upper_out = pat;
	assign video0_upper_oe = q;
	assign audio_ctrl_out = ~pat;
	assign audio_ctrl_oe = ~q;
	assign pad0_upper_in = pat ^ 8'h5a;
	assign video1_upper_out = q;
	assign video1_upper_oe = pat;
	assign audio_data_out = ~q;
	assign audio_data_oe = ~pat;
	assign pad1_upper_in = q ^ 8'h5a;

	peripheral_select_pin_mux i_dut
	(
		.mclk, .reset_n, .pci_select_strap, .ethernet_select_strap, .host_width_strap,
		.config_bus_req, .config_bus_write, .config_bus_addr, .config_bus_wdata,
		.config_bus_ack, .config_bus_rdata, .host_port_enable, .host_port_32bit,
		.ethernet_mac_enable, .pci_enable, .video2_enable, .video1_enable, .video0_enable,
		.two_wire_ctrl_enable, .serial1_enable, .serial0_enable, .audio_port_enable,
		.lock_state_flag, .video0_lower_out, .video0_lower_oe, .video0_lower_in,
		.serial0_out, .serial0_oe, .serial0_in, .pad0_lower_in, .pad0_lower_out,
		.pad0_lower_oe, .video1_lower_out, .video1_lower_oe, .video1_lower_in,
		.serial1_out, .serial1_oe, .serial1_in, .pad1_lower_in, .pad1_lower_out,
		.pad1_lower_oe, .video0_upper_out, .video0_upper_oe, .video0_upper_in,
		.audio_ctrl_out, .audio_ctrl_oe, .audio_ctrl_in, .pad0_upper_in, .pad0_upper_out,
		.pad0_upper_oe, .video1_upper_out, .video1_upper_oe, .video1_upper_in,
		.audio_data_out, .audio_data_oe, .audio_data_in, .pad1_upper_in, .pad1_upper_out,
		.pad1_upper_oe
	);

	////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One access: request held for one taking edge, answer looked at 1 ns after that edge
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
		input logic exp_ack, input logic [31:0] exp_rd);
		@(posedge mclk);
		config_bus_req <= 1'b1;
		config_bus_write <= wr;
		config_bus_addr <= a;
		config_bus_wdata <= d;
		@(posedge mclk);
		config_bus_req <= 1'b0;
		#1;
		check(config_bus_ack, exp_ack);
		if (!wr && exp_ack)
			check(config_bus_rdata, exp_rd);
	endtask

	task automatic set_cfg(input logic [31:0] v);
		bus(1'b1, CONFIG_LOCK_ADDR, UNLOCK_KEY, 1'b1, 32'h0);
		bus(1'b1, PERIPHERAL_CONFIG_ADDR, v, 1'b1, 32'h0);
	endtask

	task automatic do_reset();
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
	endtask

	// Owner: 0 none, 1 video function, 2 alternate function
	task automatic check_group(input int owner, input logic [7:0] vo, input logic [7:0] voe,
		input logic [7:0] fo, input logic [7:0] foe, input logic [7:0] pin,
		input logic [7:0] pout, input logic [7:0] poe, input logic [7:0] vin,
		input logic [7:0] fin);
		check(poe, owner == 1 ? voe : owner == 2 ? foe : 8'h00);
		check(pout, owner == 1 ? vo : owner == 2 ? fo : 8'h00);
		check(vin, owner == 1 ? pin : 8'h00);
		check(fin, owner == 2 ? pin : 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset_values();
		bus(1'b0, PERIPHERAL_CONFIG_ADDR, 32'h0, 1'b1, 32'h00000006);
		bus(1'b0, CONFIG_LOCK_ADDR, 32'h0, 1'b1, 32'h00000001);
		check({video2_enable, video1_enable, video0_enable, two_wire_ctrl_enable,
			serial1_enable, serial0_enable, audio_port_enable}, 32'h06);
	endtask

	task automatic t_lock();
		bus(1'b1, PERIPHERAL_CONFIG_ADDR, 32'h0000007f, 1'b1, 32'h0);
		bus(1'b0, PERIPHERAL_CONFIG_ADDR, 32'h0, 1'b1, 32'h00000006);
		bus(1'b1, CONFIG_LOCK_ADDR, UNLOCK_KEY, 1'b1, 32'h0);
		check(lock_state_flag, 1'b0);
		bus(1'b0, CONFIG_LOCK_ADDR, 32'h0, 1'b1, 32'h00000000);
		bus(1'b1, PERIPHERAL_CONFIG_ADDR, 32'hffffffb1, 1'b1, 32'h0);
		check(lock_state_flag, 1'b1);
		bus(1'b0, PERIPHERAL_CONFIG_ADDR, 32'h0, 1'b1, 32'h00000031);
		bus(1'b1, PERIPHERAL_CONFIG_ADDR, 32'h0000004e, 1'b1, 32'h0);
		bus(1'b0, PERIPHERAL_CONFIG_ADDR, 32'h0, 1'b1, 32'h00000031);
		bus(1'b1, CONFIG_LOCK_ADDR, UNLOCK_KEY, 1'b1, 32'h0);
		bus(1'b1, CONFIG_LOCK_ADDR, 32'h10c0010d, 1'b1, 32'h0);
		check(lock_state_flag, 1'b1);
	endtask

	task automatic t_region();
		bus(1'b0, 32'h01b3effc, 32'h0, 1'b0, 32'h0);
		bus(1'b0, 32'h01b40000, 32'h0, 1'b0, 32'h0);
		bus(1'b0, 32'h01b3f004, 32'h0, 1'b1, 32'h0);
		bus(1'b1, 32'h01b3fffc, 32'hffffffff, 1'b1, 32'h0);
		bus(1'b0, 32'h01b3fffc, 32'h0, 1'b1, 32'h0);
		bus(1'b0, PERIPHERAL_CONFIG_ADDR, 32'h0, 1'b1, 32'h00000031);
	endtask

	task automatic t_pins();
		logic [6:0] cfgs [5];
		logic [6:0] c;
		cfgs = '{7'h06, 7'h31, 7'h30, 7'h01, 7'h76};
		foreach (cfgs[i])
		begin
			c = cfgs[i];
			set_cfg({25'h0, c});
			bus(1'b0, PERIPHERAL_CONFIG_ADDR, 32'h0, 1'b1, {25'h0, c});
			repeat (128) @(posedge mclk);
			for (int k = 0; k < 2; k++)
			begin
				@(posedge mclk);
				pat <= k ? 8'h39 : 8'ha6;
				repeat (2) @(posedge mclk);
				#1;
				check({video2_enable, video1_enable, video0_enable, two_wire_ctrl_enable,
					serial1_enable, serial0_enable, audio_port_enable}, c);
				check_group(c[1] ? 2 : c[4] ? 1 : 0, video0_lower_out, video0_lower_oe,
					serial0_out, serial0_oe, pad0_lower_in, pad0_lower_out, pad0_lower_oe,
					video0_lower_in, serial0_in);
				check_group(c[2] ? 2 : c[5] ? 1 : 0, video1_lower_out, video1_lower_oe,
					serial1_out, serial1_oe, pad1_lower_in, pad1_lower_out, pad1_lower_oe,
					video1_lower_in, serial1_in);
				check_group(c[0] ? 2 : c[4] ? 1 : 0, video0_upper_out, video0_upper_oe,
					audio_ctrl_out, audio_ctrl_oe, pad0_upper_in, pad0_upper_out, pad0_upper_oe,
					video0_upper_in, audio_ctrl_in);
				check_group(c[0] ? 2 : c[5] ? 1 : 0, video1_upper_out, video1_upper_oe,
					audio_data_out, audio_data_oe, pad1_upper_in, pad1_upper_out, pad1_upper_oe,
					video1_upper_in, audio_data_in);
			end
		end
	endtask

	// Every strap code through a reset; straps move afterwards and must not matter
	task automatic t_straps();
		logic [3:0] exp;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge mclk);
			{pci_select_strap, ethernet_select_strap, host_width_strap} <= i[2:0];
			do_reset();
			case (i[2:1])
				2'b00: exp = {1'b1, i[0], 2'b00};
				2'b01: exp = {~i[0], 1'b0, 1'b1, 1'b0};
				2'b10: exp = 4'b0001;
				default: exp = 4'b0000;
			endcase
			@(posedge mclk);
			{pci_select_strap, ethernet_select_strap, host_width_strap} <= ~i[2:0];
			repeat (2) @(posedge mclk);
			#1;
			check({host_port_enable, host_port_32bit, ethernet_mac_enable, pci_enable},
				exp);
			bus(1'b0, PERIPHERAL_CONFIG_ADDR, 32'h0, 1'b1, 32'h00000006);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and main sequence
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial
	begin
		#200000;
		bad_count++;
		close_out();
	end

	initial
	begin
		bad_count = 0;
		n_compared = 0;
		reset_n = 1'b0;
		{pci_select_strap, ethernet_select_strap, host_width_strap} = 3'b000;
		config_bus_req = 1'b0;
		config_bus_write = 1'b0;
		config_bus_addr = 32'h0;
		config_bus_wdata = 32'h0;
		pat = 8'ha6;
		do_reset();
		t_reset_values();
		t_lock();
		t_region();
		t_pins();
		t_straps();
		close_out();
	end
endmodule

`default_nettype wire
